// ### rtl/b3da_unit.sv
`timescale 1ns/100ps
// Overview of operation
// RULE1 - Read coordinates, write offset to destination.
// RULE2 - Size code 0..5 selects 64..2048.
// RULE3 - Codes above five give undefined results.
// RULE4 - High size bits ignored; 6,7 act as 5.
// RULE5 - Z, Y, X integer fields decoded.
// RULE6 - Fraction bits never affect the offset.
// RULE7 - Lower and middle fields from low bits.
// RULE8 - Upper field holds X, Y, Z high.
// RULE9 - Code zero puts Z high at 20:17.
// RULE10 - Bits above Z upper read zero.
// RULE11 - X, Y bits beyond size ignored.
// RULE12 - Half shifts by one, word by two.
// RULE13 - Low zero count follows element size.
// RULE14 - Software keeps equal XY and blocked layout.
// RULE15 - Combinational, one cycle, never faults.
module b3da_unit (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire b3da_pkg::b3da_req_type req,
  output b3da_pkg::b3da_resp_type     resp
);

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    b3da_pkg::b3da_resp_type out;
  } b3da_state_type;

  b3da_state_type state_reg;
  b3da_state_type state_next;
  logic [2:0]     size_code;
  logic [63:0]    byte_offset;
  logic [63:0]    scaled;
  logic [63:0]    coord_clean;
  logic [63:0]    clean_offset;

  // Codes 6 and 7 clamp to 5 and the upper operand bits are dropped.
  always_comb begin
    if (req.size[2:0] > b3da_pkg::SIZE_CODE_MAX) begin
      size_code = b3da_pkg::SIZE_CODE_MAX; // RULE4 RULE3
    end else begin
      size_code = req.size[2:0]; // RULE2
    end
  end

  b3da_byte_offset b3da_byte_offset_i (
    .coord     (req.coord), // RULE5
    .size_code (size_code),
    .offset    (byte_offset)
  );

  b3da_scale b3da_scale_i (
    .byte_offset (byte_offset),
    .elem        (req.elem),
    .scaled      (scaled)
  );

  // ****************************************************************
  // Reference offset with every ignored coordinate bit cleared.
  // ****************************************************************
  // A second copy of the byte datapath sees only the integer bits that the
  // size code admits, so any leak from fraction or out-of-range bits shows.
  always_comb begin
    coord_clean = '0;
    coord_clean[b3da_pkg::Z_INT_LSB +: b3da_pkg::Z_INT_W] =
      req.coord[b3da_pkg::Z_INT_LSB +: b3da_pkg::Z_INT_W];
    for (int i = 0; i < b3da_pkg::XY_INT_W; i++) begin
      if (i < b3da_pkg::UPPER_XY_LSB + int'(size_code)) begin
        coord_clean[b3da_pkg::X_INT_LSB + i] = req.coord[b3da_pkg::X_INT_LSB + i];
        coord_clean[b3da_pkg::Y_INT_LSB + i] = req.coord[b3da_pkg::Y_INT_LSB + i];
      end
    end
  end

  b3da_byte_offset b3da_byte_offset_ref_i (
    .coord     (coord_clean),
    .size_code (size_code),
    .offset    (clean_offset)
  );

  // ****************************************************************
  // Result register feeding the destination write port.
  // ****************************************************************
  always_comb begin
    state_next           = state_reg;
    state_next.out.valid = req.valid; // RULE15
    if (req.valid) begin
      state_next.out.dest = req.dest; // RULE1
      state_next.out.data = scaled;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign resp = state_reg.out;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  a_one_cycle_result: assert property (@(posedge core_clk) disable iff (rst) // RULE15
    req.valid |=> resp.valid && resp.dest == $past(req.dest))
    else $error("Result did not follow request by one cycle.");

  a_low_fields: assert property (@(posedge core_clk) disable iff (rst) // RULE7
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_BYTE |=>
      resp.data[4:0] == {$past(req.coord[55]), $past(req.coord[34:33]),
                         $past(req.coord[12:11])})
    else $error("Lower offset field wrong.");

  a_mid_fields: assert property (@(posedge core_clk) disable iff (rst) // RULE7
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_BYTE |=>
      resp.data[16:5] == {$past(req.coord[59:56]), $past(req.coord[38:35]),
                          $past(req.coord[16:13])})
    else $error("Middle offset field wrong.");

  a_zero_size_z: assert property (@(posedge core_clk) disable iff (rst) // RULE9
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_BYTE && req.size[2:0] == 3'h0 |=>
      resp.data[20:17] == $past(req.coord[63:60]) && resp.data[63:21] == 43'h0)
    else $error("Size zero upper field wrong.");

  a_top_zero: assert property (@(posedge core_clk) disable iff (rst) // RULE10
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_BYTE |=> resp.data[63:31] == 33'h0)
    else $error("Bits above Z upper not zero.");

  a_half_zero: assert property (@(posedge core_clk) disable iff (rst) // RULE13
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_HALF |=>
      resp.data[0] == 1'b0 && resp.data[2:1] == $past(req.coord[12:11]))
    else $error("Half element scaling wrong.");

  a_word_zero: assert property (@(posedge core_clk) disable iff (rst) // RULE12
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_WORD |=>
      resp.data[1:0] == 2'b00 && resp.data[3:2] == $past(req.coord[12:11]))
    else $error("Word element scaling wrong.");

  a_size_five_x: assert property (@(posedge core_clk) disable iff (rst) // RULE4
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_BYTE && req.size[2:0] >= 3'h5 |=>
      resp.data[21:17] == $past(req.coord[21:17]) &&
      resp.data[26:22] == $past(req.coord[43:39]) &&
      resp.data[30:27] == $past(req.coord[63:60]))
    else $error("Clamped size code handled wrong.");

  a_fraction_ignored: assert property (@(posedge core_clk) disable iff (rst) // RULE6
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_BYTE && req.coord[10:0] != 11'h0 |=>
      resp.data[1:0] == $past(req.coord[12:11]))
    else $error("Fraction bits disturbed offset.");

  a_zero_coord: assert property (@(posedge core_clk) disable iff (rst) // RULE6
    req.valid && req.coord[63:55] == 9'h0 && req.coord[43:33] == 11'h0 &&
      req.coord[21:11] == 11'h0 |=> resp.data == 64'h0)
    else $error("Fraction bits alone gave a nonzero offset.");

  a_ignored_bits: assert property (@(posedge core_clk) disable iff (rst) // RULE11
    req.valid |-> clean_offset == byte_offset)
    else $error("Ignored coordinate bits reached the offset.");

  // ****************************************************************
  // Result port handshake and reset checks.
  // ****************************************************************
  a_valid_pulse: assert property (@(posedge core_clk) disable iff (rst) // RULE15
    !req.valid |=> !resp.valid)
    else $error("Result valid without a request.");

  a_result_hold: assert property (@(posedge core_clk) disable iff (rst) // RULE1
    !req.valid |=> $stable(resp.dest) && $stable(resp.data))
    else $error("Result changed without a request.");

  a_reset_clear: assert property (@(posedge core_clk) // RULE15
    rst |-> !resp.valid && resp.dest == 5'h0 && resp.data == b3da_pkg::RESULT_RESET)
    else $error("Result port not clear during reset.");

  // ****************************************************************
  // Upper field placement for size codes one to four.
  // ****************************************************************
  a_size_one_upper: assert property (@(posedge core_clk) disable iff (rst) // RULE8
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_BYTE && req.size[2:0] == 3'h1 |=>
      resp.data[17] == $past(req.coord[17]) &&
      resp.data[18] == $past(req.coord[39]) &&
      resp.data[22:19] == $past(req.coord[63:60]) &&
      resp.data[63:23] == 41'h0)
    else $error("Size one upper field wrong.");

  a_size_two_upper: assert property (@(posedge core_clk) disable iff (rst) // RULE8
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_BYTE && req.size[2:0] == 3'h2 |=>
      resp.data[18:17] == $past(req.coord[18:17]) &&
      resp.data[20:19] == $past(req.coord[40:39]) &&
      resp.data[24:21] == $past(req.coord[63:60]) &&
      resp.data[63:25] == 39'h0)
    else $error("Size two upper field wrong.");

  a_size_three_upper: assert property (@(posedge core_clk) disable iff (rst) // RULE8
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_BYTE && req.size[2:0] == 3'h3 |=>
      resp.data[19:17] == $past(req.coord[19:17]) &&
      resp.data[22:20] == $past(req.coord[41:39]) &&
      resp.data[26:23] == $past(req.coord[63:60]) &&
      resp.data[63:27] == 37'h0)
    else $error("Size three upper field wrong.");

  a_size_four_upper: assert property (@(posedge core_clk) disable iff (rst) // RULE8
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_BYTE && req.size[2:0] == 3'h4 |=>
      resp.data[20:17] == $past(req.coord[20:17]) &&
      resp.data[24:21] == $past(req.coord[42:39]) &&
      resp.data[28:25] == $past(req.coord[63:60]) &&
      resp.data[63:29] == 35'h0)
    else $error("Size four upper field wrong.");

  // ****************************************************************
  // Element scaling.
  // ****************************************************************
  // The byte offset seen one cycle earlier ties the scaler to the datapath,
  // while the field checks pin the scaled positions on their own.
  a_byte_exact: assert property (@(posedge core_clk) disable iff (rst) // RULE13
    req.valid && req.elem != b3da_pkg::B3DA_ELEM_HALF &&
      req.elem != b3da_pkg::B3DA_ELEM_WORD |=> resp.data == $past(byte_offset))
    else $error("Byte element result was scaled.");

  a_half_shift: assert property (@(posedge core_clk) disable iff (rst) // RULE12
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_HALF |=>
      resp.data == {$past(byte_offset[62:0]), 1'b0})
    else $error("Half element shift wrong.");

  a_word_shift: assert property (@(posedge core_clk) disable iff (rst) // RULE12
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_WORD |=>
      resp.data == {$past(byte_offset[61:0]), 2'b00})
    else $error("Word element shift wrong.");

  a_half_fields: assert property (@(posedge core_clk) disable iff (rst) // RULE12
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_HALF |=>
      resp.data[17:1] == {$past(req.coord[59:56]), $past(req.coord[38:35]),
                          $past(req.coord[16:13]), $past(req.coord[55]),
                          $past(req.coord[34:33]), $past(req.coord[12:11])})
    else $error("Half element low fields wrong.");

  a_word_fields: assert property (@(posedge core_clk) disable iff (rst) // RULE12
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_WORD |=>
      resp.data[18:2] == {$past(req.coord[59:56]), $past(req.coord[38:35]),
                          $past(req.coord[16:13]), $past(req.coord[55]),
                          $past(req.coord[34:33]), $past(req.coord[12:11])})
    else $error("Word element low fields wrong.");

  a_half_top_zero: assert property (@(posedge core_clk) disable iff (rst) // RULE10
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_HALF |=> resp.data[63:32] == 32'h0)
    else $error("Half element top bits not zero.");

  a_word_top_zero: assert property (@(posedge core_clk) disable iff (rst) // RULE10
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_WORD |=> resp.data[63:33] == 31'h0)
    else $error("Word element top bits not zero.");

  a_half_size_zero: assert property (@(posedge core_clk) disable iff (rst) // RULE9
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_HALF && req.size[2:0] == 3'h0 |=>
      resp.data[21:18] == $past(req.coord[63:60]) && resp.data[63:22] == 42'h0)
    else $error("Half size zero upper field wrong.");

  a_half_size_one: assert property (@(posedge core_clk) disable iff (rst) // RULE12
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_HALF && req.size[2:0] == 3'h1 |=>
      resp.data[18] == $past(req.coord[17]) &&
      resp.data[19] == $past(req.coord[39]) &&
      resp.data[23:20] == $past(req.coord[63:60]) &&
      resp.data[63:24] == 40'h0)
    else $error("Half size one upper field wrong.");

  a_half_size_two: assert property (@(posedge core_clk) disable iff (rst) // RULE12
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_HALF && req.size[2:0] == 3'h2 |=>
      resp.data[19:18] == $past(req.coord[18:17]) &&
      resp.data[21:20] == $past(req.coord[40:39]) &&
      resp.data[25:22] == $past(req.coord[63:60]) &&
      resp.data[63:26] == 38'h0)
    else $error("Half size two upper field wrong.");

  a_half_size_three: assert property (@(posedge core_clk) disable iff (rst) // RULE12
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_HALF && req.size[2:0] == 3'h3 |=>
      resp.data[20:18] == $past(req.coord[19:17]) &&
      resp.data[23:21] == $past(req.coord[41:39]) &&
      resp.data[27:24] == $past(req.coord[63:60]) &&
      resp.data[63:28] == 36'h0)
    else $error("Half size three upper field wrong.");

  a_half_size_four: assert property (@(posedge core_clk) disable iff (rst) // RULE12
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_HALF && req.size[2:0] == 3'h4 |=>
      resp.data[21:18] == $past(req.coord[20:17]) &&
      resp.data[25:22] == $past(req.coord[42:39]) &&
      resp.data[29:26] == $past(req.coord[63:60]) &&
      resp.data[63:30] == 34'h0)
    else $error("Half size four upper field wrong.");

  a_half_size_five: assert property (@(posedge core_clk) disable iff (rst) // RULE4
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_HALF && req.size[2:0] >= 3'h5 |=>
      resp.data[22:18] == $past(req.coord[21:17]) &&
      resp.data[27:23] == $past(req.coord[43:39]) &&
      resp.data[31:28] == $past(req.coord[63:60]) &&
      resp.data[63:32] == 32'h0)
    else $error("Half clamped size upper field wrong.");

  a_word_size_zero: assert property (@(posedge core_clk) disable iff (rst) // RULE9
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_WORD && req.size[2:0] == 3'h0 |=>
      resp.data[22:19] == $past(req.coord[63:60]) && resp.data[63:23] == 41'h0)
    else $error("Word size zero upper field wrong.");

  a_word_size_two: assert property (@(posedge core_clk) disable iff (rst) // RULE12
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_WORD && req.size[2:0] == 3'h2 |=>
      resp.data[20:19] == $past(req.coord[18:17]) &&
      resp.data[22:21] == $past(req.coord[40:39]) &&
      resp.data[26:23] == $past(req.coord[63:60]) &&
      resp.data[63:27] == 37'h0)
    else $error("Word size two upper field wrong.");

  a_word_size_five: assert property (@(posedge core_clk) disable iff (rst) // RULE4
    req.valid && req.elem == b3da_pkg::B3DA_ELEM_WORD && req.size[2:0] >= 3'h5 |=>
      resp.data[32:29] == $past(req.coord[63:60]) && resp.data[63:33] == 31'h0)
    else $error("Word clamped size upper field wrong.");

endmodule : b3da_unit

// ### rtl/b3da_pkg.sv
package b3da_pkg;

  // ****************************************************************
  // Coordinate word layout.
  // ****************************************************************
  localparam int X_INT_LSB = 11;
  localparam int Y_INT_LSB = 33;
  localparam int Z_INT_LSB = 55;
  localparam int XY_INT_W  = 11;
  localparam int Z_INT_W   = 9;

  // ****************************************************************
  // Size code and offset layout.
  // ****************************************************************
  localparam logic [2:0] SIZE_CODE_MAX = 3'h5;
  localparam int UPPER_LSB  = 17;
  localparam int UPPER_XY_LSB = 6;
  localparam logic [63:0] RESULT_RESET = 64'h0;

  typedef enum logic [1:0] {
    B3DA_ELEM_BYTE,
    B3DA_ELEM_HALF,
    B3DA_ELEM_WORD
  } b3da_elem_type;

  typedef struct packed {
    logic          valid;
    b3da_elem_type elem;
    logic [63:0]   coord;
    logic [63:0]   size;
    logic [4:0]    dest;
  } b3da_req_type;

  typedef struct packed {
    logic        valid;
    logic [4:0]  dest;
    logic [63:0] data;
  } b3da_resp_type;

endpackage : b3da_pkg

// ### rtl/b3da_byte_offset.sv
`timescale 1ns/100ps
module b3da_byte_offset (
  input  wire logic [63:0] coord,
  input  wire logic [2:0]  size_code,
  output logic      [63:0] offset
);

  logic [10:0] xi;
  logic [10:0] yi;
  logic [8:0]  zi;
  logic [63:0] acc;

  always_comb begin
    xi  = coord[b3da_pkg::X_INT_LSB +: b3da_pkg::XY_INT_W];
    yi  = coord[b3da_pkg::Y_INT_LSB +: b3da_pkg::XY_INT_W];
    zi  = coord[b3da_pkg::Z_INT_LSB +: b3da_pkg::Z_INT_W];
    acc = 64'h0; // RULE10 RULE6
    acc[1:0]   = xi[1:0]; // RULE7
    acc[3:2]   = yi[1:0];
    acc[4]     = zi[0];
    acc[8:5]   = xi[5:2];
    acc[12:9]  = yi[5:2];
    acc[16:13] = zi[4:1];
    // Upper field: n bits of X, n bits of Y, then four bits of Z.
    for (int i = 0; i < 5; i++) begin
      if (i < int'(size_code)) begin // RULE11
        acc[b3da_pkg::UPPER_LSB + i] = xi[b3da_pkg::UPPER_XY_LSB + i]; // RULE8
        acc[b3da_pkg::UPPER_LSB + int'(size_code) + i] = yi[b3da_pkg::UPPER_XY_LSB + i];
      end
    end
    for (int j = 0; j < 4; j++) begin
      acc[b3da_pkg::UPPER_LSB + 2 * int'(size_code) + j] = zi[5 + j]; // RULE8 RULE9
    end
    offset = acc;
  end

endmodule : b3da_byte_offset

// ### rtl/b3da_scale.sv
`timescale 1ns/100ps
module b3da_scale (
  input  wire logic [63:0]           byte_offset,
  input  wire b3da_pkg::b3da_elem_type elem,
  output logic      [63:0]           scaled
);

  always_comb begin
    case (elem)
      b3da_pkg::B3DA_ELEM_HALF: scaled = {byte_offset[62:0], 1'b0}; // RULE12 RULE13
      b3da_pkg::B3DA_ELEM_WORD: scaled = {byte_offset[61:0], 2'b00}; // RULE12 RULE13
      default:                  scaled = byte_offset; // RULE13
    endcase
  end

endmodule : b3da_scale

// ### tb/b3da_regfile.sv
`timescale 1ns/100ps
module b3da_regfile (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire b3da_pkg::b3da_resp_type resp,
  input  wire logic [4:0]              rd_idx,
  output logic      [63:0]             rd_data
);
  logic [63:0] regs_reg [32];
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 32; i++) begin
        regs_reg[i] <= 64'h0;
      end
    end else if (resp.valid) begin
      regs_reg[resp.dest] <= resp.data;
    end
  end
  assign rd_data = regs_reg[rd_idx];
endmodule : b3da_regfile

// ### tb/tb_blocked_3d_array_address.sv
`timescale 1ns/100ps
module tb_blocked_3d_array_address;
  logic                    core_clk   = 1'b0;
  logic                    rst        = 1'b0;
  b3da_pkg::b3da_req_type  req        = '0;
  b3da_pkg::b3da_resp_type resp;
  logic [4:0]              rd_idx     = 5'h0;
  logic [63:0]             rd_data;
  int                      n_mismatch = 0;
  int                      checks     = 0;
  always #10 core_clk = ~core_clk;
  b3da_unit b3da_unit_i (.core_clk(core_clk), .rst(rst), .req(req), .resp(resp));
  b3da_regfile b3da_regfile_i (.core_clk(core_clk), .rst(rst), .resp(resp),
                               .rd_idx(rd_idx), .rd_data(rd_data));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  // The expected offset is rebuilt field by field, clamping codes above five.
  function automatic logic [63:0] ref_off(input logic [63:0] c, input logic [63:0] s,
                                          input int sh);
    logic [63:0] r;
    int          n;
    n = (s[2:0] > 3'h5) ? 5 : int'(s[2:0]);
    r = {47'h0, c[59:56], c[38:35], c[16:13], c[55], c[34:33], c[12:11]};
    for (int i = 0; i < n; i++) begin
      r[17+i]   = c[17+i];
      r[17+n+i] = c[39+i];
    end
    for (int i = 0; i < 4; i++) begin
      r[17+2*n+i] = c[60+i];
    end
    return r << sh;
  endfunction : ref_off
  task automatic op(input int e, input logic [63:0] c, input logic [63:0] s,
                    input logic [4:0] d, input logic last);
    int sh;
    sh        = (e == 2) ? 2 : ((e == 1) ? 1 : 0);
    req.valid = 1'b1;
    req.elem  = b3da_pkg::b3da_elem_type'(e);
    req.coord = c;
    req.size  = s;
    req.dest  = d;
    @(posedge core_clk);
    #2;
    check({63'h0, resp.valid}, 64'h1);
    check({59'h0, resp.dest}, {59'h0, d});
    check(resp.data, ref_off(c, s, sh));
    if (last) begin
      req.valid = 1'b0;
      @(posedge core_clk);
      #2;
      check({63'h0, resp.valid}, 64'h0);
    end
  endtask : op
  task automatic t_grid();
    for (int e = 0; e < 3; e++) begin
      for (int s = 0; s < 8; s++) begin
        op(e, 64'hfedc_ba98_7654_3211, 64'(s), 5'(s), 1'b1);
      end
    end
    $display("test grid done");
  endtask : t_grid
  // Single bits walk through every field, fraction and ignored bit.
  task automatic t_fields();
    for (int b = 0; b < 64; b++) begin
      op(0, 64'h1 << b, 64'h0, 5'h1, 1'b1);
      op(2, 64'h1 << b, 64'hff00_0000_0000_0005, 5'h2, 1'b1);
    end
    $display("test fields done");
  endtask : t_fields
  task automatic t_back();
    op(1, 64'hffff_ffff_ffff_ffff, 64'h2, 5'h3, 1'b0);
    op(2, 64'h0123_4567_89ab_cdef, 64'h4, 5'h4, 1'b1);
    rd_idx = 5'h3;
    #1;
    check(rd_data, ref_off(64'hffff_ffff_ffff_ffff, 64'h2, 1));
    rd_idx = 5'h4;
    #1;
    check(rd_data, ref_off(64'h0123_4567_89ab_cdef, 64'h4, 2));
    op(3, 64'h0123_4567_89ab_cdef, 64'h1, 5'h5, 1'b1);
    $display("test back done");
  endtask : t_back
  // A reset in mid-run clears the result port at once; the next request still works.
  task automatic t_reset();
    op(0, 64'h0123_4567_89ab_cdef, 64'h3, 5'h7, 1'b0);
    req.valid = 1'b0;
    rst       = 1'b1;
    #1;
    check({63'h0, resp.valid}, 64'h0);
    check(resp.data, 64'h0);
    @(posedge core_clk);
    #2;
    rst = 1'b0;
    op(1, 64'h0123_4567_89ab_cdef, 64'h3, 5'h7, 1'b1);
    $display("test reset done");
  endtask : t_reset
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  initial begin
    #1;
    rst = 1'b1;
    repeat (3) @(posedge core_clk);
    #2;
    rst = 1'b0;
    check(resp.data, 64'h0);
    t_grid();
    t_fields();
    t_back();
    t_reset();
    complete_run();
  end
endmodule : tb_blocked_3d_array_address
